// ---- rtl/ocp_consts.svh ----
// Purpose: offsets, field positions, reset values and page codes of the output clock page bank
// Assumes: 8-bit register offsets and data
// Notes:   page codes and the second feedback divider fraction offsets are local choices
`ifndef OCP_CONSTS_SVH
`define OCP_CONSTS_SVH
`define OCP_OFF_STATUS   8'h02
`define OCP_OFF_NOTIFY   8'h03
`define OCP_OFF_NVM_LO   8'h10
`define OCP_OFF_NVM_HI   8'h2f
`define OCP_OFF_N2F_LO   8'h20
`define OCP_OFF_DELAY    8'h6c
`define OCP_OFF_DRIVER   8'h6d
`define OCP_OFF_TERM     8'h6f
`define OCP_OFF_PAGE     8'hff
`define OCP_PAGE_OUT     8'h01
`define OCP_PAGE_PLL_A   8'h0a
`define OCP_NUM_PLL      3'h4
`define OCP_NOTIFY_RST   8'hff
`define OCP_CFG_RST      8'h00
`define OCP_FINE_PS      8'h1e
`define OCP_FINE_EXT     3'h4
`define OCP_COARSE_LSB   0
`define OCP_FINE_LSB     6
`define OCP_EXT_BIT      4
`define OCP_VDD_LSB      3
`define OCP_DRV_LSB      0
`endif

// ---- rtl/ocp_pkg.sv ----
// Purpose: types shared by the output clock page bank
// Assumes: nothing beyond the constants header
// Notes:   invalid encodings decode to an explicit bad value
package ocp_pkg;
  // supply level chosen for the output
  typedef enum logic [1:0] {OCP_VDD_1V8, OCP_VDD_2V5, OCP_VDD_3V3, OCP_VDD_BAD} ocp_vdd_t;
  // driver signalling standard
  typedef enum logic [2:0] {
    OCP_DRV_LVDS, OCP_DRV_LVPECL, OCP_DRV_CML, OCP_DRV_HCSL,
    OCP_DRV_LVDS_BOOST, OCP_DRV_LVPECL_NOCM, OCP_DRV_BAD
  } ocp_drv_t;
  // termination or single-ended drive mode
  typedef enum logic [2:0] {
    OCP_TERM_EXT, OCP_TERM_PULLUP, OCP_TERM_PULLDN,
    OCP_TERM_SE_P, OCP_TERM_SE_N, OCP_TERM_SE_PN, OCP_TERM_BAD
  } ocp_term_t;
endpackage

// ---- rtl/ocp_regs.sv ----
// Purpose: paged register bank for one clock output plus the pll pages
// Assumes: register port already deserialised into byte reads and writes
// Notes:   decoded outputs trail the registers by one cycle
`timescale 1ns/100ps
`default_nettype none
`include "ocp_consts.svh"
module ocp_regs (
  input  wire logic               clk,             // 200 MHz clock
  input  wire logic               reset_n,         // async reset, active low
  input  wire logic               wr_en,           // write strobe
  input  wire logic               rd_en,           // read strobe
  input  wire logic [7:0]         addr,            // register offset
  input  wire logic [7:0]         wdata,           // write data
  input  wire logic [3:0]         pll_lol,         // live loss of lock, per pll
  output logic      [7:0]         rdata,           // read data
  output logic                    rvalid,          // read data valid pulse
  output logic      [7:0]         page,            // active page
  output logic      [5:0]         coarse_delay,    // vco periods of delay
  output logic      [2:0]         fine_code,       // fine delay increments
  output logic      [7:0]         fine_delay_ps,   // fine delay in ps
  output ocp_pkg::ocp_vdd_t       output_supply_select, // supply level
  output ocp_pkg::ocp_drv_t       driver_standard_select, // driver standard
  output ocp_pkg::ocp_term_t      term_mode,       // termination mode
  output logic      [31:0]        n2_frac_a,       // first pll, held at zero
  output logic      [31:0]        n2_frac_b,       // fraction, pll b
  output logic      [31:0]        n2_frac_c,       // fraction, pll c
  output logic      [31:0]        n2_frac_d        // fraction, pll d
);
  // register state
  logic [7:0]  page_q, page_d;            // page selector
  logic [7:0]  dly_q, dly_d;              // output_delay_ctrl
  logic [7:0]  drv_q, drv_d;              // output_driver_cfg
  logic [3:0]  term_q, term_d;            // output_termination_cfg
  logic [7:0]  notify_q [0:3];            // first_pll_sticky_flags per pll
  logic [7:0]  notify_d [0:3];
  logic [7:0]  nvm_q [0:127];             // nvm copies, 32 bytes per pll
  logic [7:0]  nvm_d [0:127];
  logic [7:0]  rdata_d;
  logic        on_out, on_pll, in_nvm;    // address decode
  logic [1:0]  pll_idx;                   // pll page index
  logic [6:0]  nvm_idx;                   // nvm array index
  logic [7:0]  pll_off;
  logic [2:0]  fine_d;
  logic [31:0] frac_d [0:3];
  // next values of the decoded outputs
  logic               rvalid_d;           // read valid, next
  logic [5:0]         coarse_d;           // coarse delay count, next
  logic [7:0]         fine_ps_d;          // fine delay in ps, next
  ocp_pkg::ocp_vdd_t  supply_d;           // supply decode, next
  ocp_pkg::ocp_drv_t  drv_std_d;          // driver decode, next
  ocp_pkg::ocp_term_t term_mode_d;        // termination decode, next

  // page decode; every offset but the selector goes to the active page
  always_comb begin
    pll_off = page_q - `OCP_PAGE_PLL_A;
    on_out  = (page_q == `OCP_PAGE_OUT);
    on_pll  = (pll_off < {5'h00, `OCP_NUM_PLL});
    pll_idx = pll_off[1:0];
    in_nvm  = on_pll && (addr >= `OCP_OFF_NVM_LO) && (addr <= `OCP_OFF_NVM_HI);
    nvm_idx = {pll_idx, addr[4:0] ^ 5'h10};
  end

  // next state of all writable registers
  always_comb begin
    page_d = page_q;
    dly_d  = dly_q;
    drv_d  = drv_q;
    term_d = term_q;
    nvm_d  = nvm_q;
    for (int i = 0; i < 4; i++) begin
      notify_d[i] = notify_q[i] | {7'h00, pll_lol[i]};
    end
    if (wr_en) begin
      if (addr == `OCP_OFF_PAGE) begin
        page_d = wdata;
      end else if (on_out) begin
        if (addr == `OCP_OFF_DELAY)  dly_d  = wdata;
        if (addr == `OCP_OFF_DRIVER) drv_d  = wdata;
        if (addr == `OCP_OFF_TERM)   term_d = wdata[3:0];
      end else if (on_pll) begin
        // software writes, hardware set still wins
        if (addr == `OCP_OFF_NOTIFY) begin
          notify_d[pll_idx] = wdata | {7'h00, pll_lol[pll_idx]};
        end
        if (in_nvm) nvm_d[nvm_idx] = wdata;
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    if (addr == `OCP_OFF_PAGE) begin
      rdata_d = page_q;
    end else if (on_out) begin
      case (addr)
        `OCP_OFF_DELAY:  rdata_d = dly_q;
        `OCP_OFF_DRIVER: rdata_d = drv_q;
        `OCP_OFF_TERM:   rdata_d = {4'h0, term_q};
        default:         rdata_d = 8'h00;
      endcase
    end else if (on_pll) begin
      if (addr == `OCP_OFF_STATUS) rdata_d = {7'h00, pll_lol[pll_idx]};
      if (addr == `OCP_OFF_NOTIFY) rdata_d = notify_q[pll_idx];
      if (in_nvm) rdata_d = nvm_q[nvm_idx];
    end
    // hold the last byte read when no read is taken this cycle
    if (!rd_en) rdata_d = rdata;
    // rvalid marks exactly the cycle after a taken read
    rvalid_d = rd_en;
  end

  // field decode for the output driver; every decoded output but page gets its next value here
  always_comb begin
    coarse_d  = dly_q[`OCP_COARSE_LSB +: 6];
    fine_d    = drv_q[`OCP_EXT_BIT] ? `OCP_FINE_EXT : {1'b0, dly_q[`OCP_FINE_LSB +: 2]};
    // fine delay scaling; four steps of 30 ps still fit a byte
    fine_ps_d = 8'(fine_d * `OCP_FINE_PS);
    // supply decode; the reserved code is flagged rather than folded onto a level
    case (drv_q[`OCP_VDD_LSB +: 2])
      2'h0:    supply_d = ocp_pkg::OCP_VDD_1V8;
      2'h1:    supply_d = ocp_pkg::OCP_VDD_2V5;
      2'h2:    supply_d = ocp_pkg::OCP_VDD_3V3;
      default: supply_d = ocp_pkg::OCP_VDD_BAD;
    endcase
    // driver standard decode; codes six and seven select no driver
    case (drv_q[`OCP_DRV_LSB +: 3])
      3'h0:    drv_std_d = ocp_pkg::OCP_DRV_LVDS;
      3'h1:    drv_std_d = ocp_pkg::OCP_DRV_LVPECL;
      3'h2:    drv_std_d = ocp_pkg::OCP_DRV_CML;
      3'h3:    drv_std_d = ocp_pkg::OCP_DRV_HCSL;
      3'h4:    drv_std_d = ocp_pkg::OCP_DRV_LVDS_BOOST;
      3'h5:    drv_std_d = ocp_pkg::OCP_DRV_LVPECL_NOCM;
      default: drv_std_d = ocp_pkg::OCP_DRV_BAD;
    endcase
    // termination decode; anything outside the six codes is flagged
    case (term_q)
      4'h0:    term_mode_d = ocp_pkg::OCP_TERM_EXT;
      4'h2:    term_mode_d = ocp_pkg::OCP_TERM_PULLUP;
      4'h1:    term_mode_d = ocp_pkg::OCP_TERM_PULLDN;
      4'h4:    term_mode_d = ocp_pkg::OCP_TERM_SE_P;
      4'h8:    term_mode_d = ocp_pkg::OCP_TERM_SE_N;
      4'hc:    term_mode_d = ocp_pkg::OCP_TERM_SE_PN;
      default: term_mode_d = ocp_pkg::OCP_TERM_BAD;
    endcase
    // fraction bytes sit at 20h..23h of each pll page, lowest byte first
    for (int i = 0; i < 4; i++) begin
      frac_d[i] = {nvm_q[i*32+19], nvm_q[i*32+18], nvm_q[i*32+17], nvm_q[i*32+16]};
    end
    frac_d[0] = 32'h0000_0000;
  end

  // registers; configuration resets to zero, the sticky flags reset to all ones
  // rdata keeps the last byte read so a slow host may pick it up late
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page_q <= `OCP_CFG_RST;
      dly_q  <= `OCP_CFG_RST;
      drv_q  <= `OCP_CFG_RST;
      term_q <= 4'h0;
      rdata  <= 8'h00;
      rvalid <= 1'b0;
      for (int i = 0; i < 4; i++) notify_q[i] <= `OCP_NOTIFY_RST;
      for (int j = 0; j < 128; j++) nvm_q[j] <= 8'h00;
    end else begin
      page_q   <= page_d;
      dly_q    <= dly_d;
      drv_q    <= drv_d;
      term_q   <= term_d;
      notify_q <= notify_d;
      nvm_q    <= nvm_d;
      rvalid   <= rvalid_d;
      rdata    <= rdata_d;
    end
  end

  // decoded outputs, registered so they are glitch free toward the analog side
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page                   <= 8'h00;
      coarse_delay           <= 6'h00;
      fine_code              <= 3'h0;
      fine_delay_ps          <= 8'h00;
      output_supply_select   <= ocp_pkg::OCP_VDD_1V8;
      driver_standard_select <= ocp_pkg::OCP_DRV_LVDS;
      term_mode              <= ocp_pkg::OCP_TERM_EXT;
      n2_frac_a              <= 32'h0000_0000;
      n2_frac_b              <= 32'h0000_0000;
      n2_frac_c              <= 32'h0000_0000;
      n2_frac_d              <= 32'h0000_0000;
    end else begin
      // plain register stage; all decoding sits in the process above
      page                   <= page_q;
      coarse_delay           <= coarse_d;
      fine_code              <= fine_d;
      fine_delay_ps          <= fine_ps_d;
      output_supply_select   <= supply_d;
      driver_standard_select <= drv_std_d;
      term_mode              <= term_mode_d;
      n2_frac_a              <= frac_d[0];
      n2_frac_b              <= frac_d[1];
      n2_frac_c              <= frac_d[2];
      n2_frac_d              <= frac_d[3];
    end
  end

  // checks
  sequence s_page_wr;
    wr_en && addr == `OCP_OFF_PAGE;
  endsequence
  sequence s_nvm_wr;
    wr_en && in_nvm;
  endsequence
  sequence s_notify_wr;
    wr_en && on_pll && addr == `OCP_OFF_NOTIFY;
  endsequence

  a_page_write: assert property (@(posedge clk) disable iff (!reset_n)
    s_page_wr |=> page_q == $past(wdata) ##1 page == $past(wdata, 2))
    else $error("page selector write lost");
  a_coarse_field: assert property (@(posedge clk) disable iff (!reset_n)
    wr_en && on_out && addr == `OCP_OFF_DELAY && addr != `OCP_OFF_PAGE
    |=> ##1 coarse_delay == $past(wdata[5:0], 2))
    else $error("coarse delay mismatch");
  a_fine_scale: assert property (@(posedge clk) disable iff (!reset_n)
    !drv_q[`OCP_EXT_BIT] |=> fine_delay_ps == 8'($past(dly_q[7:6]) * 8'h1e))
    else $error("fine delay scaling wrong");
  a_fine_ext: assert property (@(posedge clk) disable iff (!reset_n)
    drv_q[`OCP_EXT_BIT] |=> fine_code == 3'h4 && fine_delay_ps == 8'h78)
    else $error("extended fine delay wrong");
  a_supply_3v3: assert property (@(posedge clk) disable iff (!reset_n)
    drv_q[4:3] == 2'h2 |=> output_supply_select == ocp_pkg::OCP_VDD_3V3)
    else $error("supply decode wrong");
  a_driver_cml: assert property (@(posedge clk) disable iff (!reset_n)
    drv_q[2:0] == 3'h2 |=> driver_standard_select == ocp_pkg::OCP_DRV_CML)
    else $error("driver decode wrong");
  a_term_both: assert property (@(posedge clk) disable iff (!reset_n)
    term_q == 4'hc |=> term_mode == ocp_pkg::OCP_TERM_SE_PN)
    else $error("termination decode wrong");
  a_nvm_copy: assert property (@(posedge clk) disable iff (!reset_n)
    s_nvm_wr ##1 (rd_en && addr == $past(addr) && page_q == $past(page_q) && !wr_en)
    |=> rvalid && rdata == $past(wdata, 2))
    else $error("nvm copy readback wrong");
  a_frac_first: assert property (@(posedge clk) disable iff (!reset_n)
    n2_frac_a == 32'h0000_0000)
    else $error("first pll fraction not ignored");
  a_lock_live: assert property (@(posedge clk) disable iff (!reset_n)
    rd_en && page_q == `OCP_PAGE_PLL_A && addr == `OCP_OFF_STATUS
    |=> rdata == {7'h00, $past(pll_lol[0])})
    else $error("live lock status wrong");
  a_sticky_set: assert property (@(posedge clk) disable iff (!reset_n)
    pll_lol[0] |=> notify_q[0][0])
    else $error("sticky flag missed event");
  a_route_page: assert property (@(posedge clk) disable iff (!reset_n)
    wr_en && !on_out && addr == `OCP_OFF_DELAY |=> $stable(dly_q))
    else $error("write leaked to other page");

  // a software write lands when no lock event competes with it
  a_notify_write: assert property (@(posedge clk) disable iff (!reset_n)
    s_notify_wr ##0 (pll_idx == 2'h0 && !pll_lol[0]) |=> notify_q[0] == $past(wdata))
    else $error("notify write lost");
  a_supply_1v8: assert property (@(posedge clk) disable iff (!reset_n)
    drv_q[4:3] == 2'h0 |=> output_supply_select == ocp_pkg::OCP_VDD_1V8)
    else $error("supply default decode wrong");
  a_drv_lvds: assert property (@(posedge clk) disable iff (!reset_n)
    drv_q[2:0] == 3'h0 |=> driver_standard_select == ocp_pkg::OCP_DRV_LVDS)
    else $error("driver default decode wrong");
  a_term_pullup: assert property (@(posedge clk) disable iff (!reset_n)
    term_q == 4'h2 |=> term_mode == ocp_pkg::OCP_TERM_PULLUP)
    else $error("pull-up decode wrong");
  a_page_rdback: assert property (@(posedge clk) disable iff (!reset_n)
    rd_en && addr == `OCP_OFF_PAGE |=> rdata == $past(page_q))
    else $error("page selector readback wrong");
  a_frac_pll_b: assert property (@(posedge clk) disable iff (!reset_n)
    n2_frac_b == {$past(nvm_q[51]), $past(nvm_q[50]), $past(nvm_q[49]), $past(nvm_q[48])})
    else $error("second pll fraction wrong");
  a_lock_pll_c: assert property (@(posedge clk) disable iff (!reset_n)
    rd_en && page_q == `OCP_PAGE_PLL_A + 8'h02 && addr == `OCP_OFF_STATUS
    |=> rdata == {7'h00, $past(pll_lol[2])})
    else $error("third pll lock status wrong");
endmodule
`default_nettype wire

// ---- dv/ocp_regs_tb.sv ----
// Purpose: self-checking bench for the output clock page bank
// Assumes: byte strobes driven on the falling edge, mostly one idle cycle between accesses
// Notes:   decoded outputs trail a write by two edges, so checks wait two cycles
`timescale 1ns/100ps
`default_nettype none
`include "ocp_consts.svh"
module ocp_regs_tb;
  logic               clk;           // bench clock, 5 ns period
  logic               reset_n;       // active low reset
  logic               wr_en;         // write strobe
  logic               rd_en;         // read strobe
  logic [7:0]         addr;          // register offset
  logic [7:0]         wdata;         // write byte
  logic [3:0]         pll_lol;       // live lock loss per pll
  logic [7:0]         rdata;         // read byte
  logic               rvalid;        // read valid pulse
  logic [7:0]         page;          // active page
  logic [5:0]         coarse_delay;  // coarse delay count
  logic [2:0]         fine_code;     // fine delay steps
  logic [7:0]         fine_delay_ps; // fine delay in ps
  ocp_pkg::ocp_vdd_t  vdd;           // supply decode
  ocp_pkg::ocp_drv_t  drv;           // driver decode
  ocp_pkg::ocp_term_t term;          // termination decode
  logic [31:0]        frac [4];      // feedback fraction per pll
  int                 mismatches;    // failed compares
  int                 comparisons;   // all compares
  logic [3:0]         codes [6];     // termination encodings in enum order

  ocp_regs ocp_regs_i (.clk(clk), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .pll_lol(pll_lol), .rdata(rdata), .rvalid(rvalid),
    .page(page), .coarse_delay(coarse_delay), .fine_code(fine_code),
    .fine_delay_ps(fine_delay_ps), .output_supply_select(vdd),
    .driver_standard_select(drv), .term_mode(term), .n2_frac_a(frac[0]),
    .n2_frac_b(frac[1]), .n2_frac_c(frac[2]), .n2_frac_d(frac[3]));

  // free running clock
  always #2.5 clk = ~clk;

  // one compare for every kind of result, zero-extended to 32 bits
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // byte write; the leading idle cycle keeps strobes from being set twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  // byte read, judged in the cycle rvalid stands
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd_en = 1'b1;
    addr  = a;
    @(negedge clk);
    rd_en = 1'b0;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("rdata", {24'h0, exp}, {24'h0, rdata});
  endtask

  // write then read the same offset on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("rdata", {24'h0, d}, {24'h0, rdata});
  endtask

  // let decoded outputs catch up with the registers
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic t_reset();
    chk("page", 32'h0, {24'h0, page});
    chk("coarse", 32'h0, {26'h0, coarse_delay});
    chk("fine", 32'h0, {24'h0, fine_delay_ps});
    chk("decodes", 32'h0, {24'h0, vdd, drv, term});
    rd(8'hff, 8'h00);
    // a write on an unmapped page must not reach the output registers
    wr(8'h6c, 8'h55);
    settle();
    chk("coarse", 32'h0, {26'h0, coarse_delay});
    wr(8'hff, `OCP_PAGE_OUT);
    rd(8'h6c, 8'h00);
    rd(8'h00, 8'h00);
  endtask

  task automatic t_delay();
    wr(8'h6c, 8'hc5);
    settle();
    chk("coarse", 32'h5, {26'h0, coarse_delay});
    chk("fine_ps", 32'h5a, {24'h0, fine_delay_ps});
    wr(8'h6c, 8'h3f);
    settle();
    chk("coarse", 32'h3f, {26'h0, coarse_delay});
    chk("fine_code", 32'h0, {29'h0, fine_code});
    rd(8'h6c, 8'h3f);
  endtask

  task automatic t_driver();
    for (int v = 0; v < 3; v++) begin
      for (int d = 0; d < 6; d++) begin
        wr(8'h6d, {3'h0, v[1:0], d[2:0]});
        settle();
        chk("vdd", v, {30'h0, vdd});
        chk("drv", d, {29'h0, drv});
      end
    end
    // reserved supply and driver codes are flagged
    wr(8'h6d, 8'h1f);
    settle();
    chk("vdd", ocp_pkg::OCP_VDD_BAD, {30'h0, vdd});
    chk("drv", ocp_pkg::OCP_DRV_BAD, {29'h0, drv});
    // extended fine bit overrides the two-bit code
    wr(8'h6d, 8'h10);
    settle();
    chk("fine_code", 32'h4, {29'h0, fine_code});
    chk("fine_ps", 32'h78, {24'h0, fine_delay_ps});
  endtask

  task automatic t_term();
    codes = '{4'h0, 4'h2, 4'h1, 4'h4, 4'h8, 4'hc};
    for (int i = 0; i < 6; i++) begin
      wr(8'h6f, {4'ha, codes[i]});
      settle();
      chk("term", i, {29'h0, term});
      rd(8'h6f, {4'h0, codes[i]});
    end
    wr(8'h6f, 8'h03);
    settle();
    chk("term", ocp_pkg::OCP_TERM_BAD, {29'h0, term});
  endtask

  task automatic t_pll_page();
    wr(8'hff, `OCP_PAGE_PLL_A);
    settle();
    chk("page", 32'h0a, {24'h0, page});
    rd(8'hff, 8'h0a);
    rd(8'h03, 8'hff);
    rd(8'h02, 8'h00);
    pll_lol = 4'h1;
    rd(8'h02, 8'h01);
    pll_lol = 4'h0;
    rd(8'h02, 8'h00);
    wr(8'h03, 8'h00);
    rd(8'h03, 8'h00);
    // a single-cycle lock loss must leave the sticky bit set
    @(negedge clk);
    pll_lol = 4'h1;
    @(negedge clk);
    pll_lol = 4'h0;
    rd(8'h03, 8'h01);
    // an event in the cycle of a clearing write keeps the flag set
    pll_lol = 4'h1;
    wr(8'h03, 8'h00);
    pll_lol = 4'h0;
    rd(8'h03, 8'h01);
    // the third pll page reads its own lock input only
    wr(8'hff, `OCP_PAGE_PLL_A + 8'h02);
    rd(8'h03, 8'hff);
    pll_lol = 4'h1;
    rd(8'h02, 8'h00);
    pll_lol = 4'h4;
    rd(8'h02, 8'h01);
    pll_lol = 4'h0;
  endtask

  task automatic t_frac();
    for (int p = 0; p < 4; p++) begin
      wr(8'hff, 8'h0a + p[7:0]);
      for (int b = 0; b < 4; b++) wr(8'h20 + b[7:0], 8'h10 * (b[7:0] + 8'h1) + p[7:0]);
      settle();
      chk("frac", p == 0 ? 32'h0 : 32'h40302010 + 32'h01010101 * p, frac[p]);
      rd(8'h20, 8'h10 + p[7:0]);
      rd(8'h2f, 8'h00);
      wr_rd(8'h2e, 8'ha0 + p[7:0]);
    end
  endtask

  // single place where the run ends
  task automatic wrap_up();
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog sized well above the few hundred cycles the tests take
  initial begin
    repeat (8000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    pll_lol = 4'h0;
    mismatches = 0;
    comparisons = 0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_delay();
    t_driver();
    t_term();
    t_pll_page();
    t_frac();
    wrap_up();
  end
endmodule
`default_nettype wire
